/* core/rts_pkg.sv */
// package for the ramp time selector: register map, field layouts, reset values, timing
package rts_pkg;
  localparam logic [7:0]  ADDR_ACCEL_A     = 8'h00;
  localparam logic [7:0]  ADDR_DECEL_A     = 8'h04;
  localparam logic [7:0]  ADDR_ACCEL_B     = 8'h08;
  localparam logic [7:0]  ADDR_DECEL_B     = 8'h0c;
  localparam logic [7:0]  ADDR_ACCEL_C     = 8'h10;
  localparam logic [7:0]  ADDR_DECEL_C     = 8'h14;
  localparam logic [7:0]  ADDR_ACCEL_D     = 8'h18;
  localparam logic [7:0]  ADDR_DECEL_D     = 8'h1c;
  localparam logic [7:0]  ADDR_HALT_TIME   = 8'h20;
  localparam logic [7:0]  ADDR_UNIT_SEL    = 8'h24;
  localparam logic [7:0]  ADDR_SWITCH_FREQ = 8'h28;
  localparam logic [7:0]  ADDR_MAX_FREQ    = 8'h2c;
  localparam logic [7:0]  ADDR_FUNC_CFG    = 8'h30;
  localparam logic [7:0]  ADDR_STATUS      = 8'h34;
  localparam logic [7:0]  ADDR_IRQ_STAT    = 8'h38;
  localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h3c;

  localparam logic [15:0] ACCEL_RST        = 16'h0258;
  localparam logic [15:0] DECEL_RST        = 16'h04b0;
  localparam logic [15:0] HALT_TIME_RST    = 16'h04b0;
  localparam logic        UNIT_SEL_RST     = 1'b1;
  localparam logic [15:0] SWITCH_FREQ_RST  = 16'h0000;
  localparam logic [15:0] MAX_FREQ_RST     = 16'h0258;
  localparam logic [15:0] UNIT_FINE_LIMIT  = 16'h1771;

  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  localparam int          IRQ_HALT         = 0;
  localparam int          IRQ_PAIR         = 1;
  localparam int          IRQ_UNIT_REJ     = 2;
  localparam int          IRQ_CONFLICT     = 3;
  localparam int          IRQ_W            = 4;

  localparam int          CLK_MHZ          = 250;
  localparam int          TICK_FINE_US     = 10000;
  localparam int          TICK_COARSE_US   = 100000;
  localparam int          TICK_FINE_CYC    = TICK_FINE_US * CLK_MHZ;
  localparam int          TICK_COARSE_CYC  = TICK_COARSE_US * CLK_MHZ;
  localparam logic [5:0]  DIV_STEPS        = 6'h20;

  typedef struct packed {
    logic overheat_act;
    logic coast_stop;
    logic pm_motor;
    logic halt_stat_out;
    logic halt_nc;
    logic halt_no;
    logic motor_sel;
    logic sel2;
    logic sel1;
  } rts_cfg_s;

  typedef struct packed {
    logic sel1;
    logic sel2;
    logic motor;
    logic halt;
    logic run_cmd;
    logic overheat_prealarm;
    logic fault_halt_req;
    logic freq_zero;
    logic ramp_up;
  } rts_in_s;

  typedef struct packed {
    logic [3:0][15:0]    accel;
    logic [3:0][15:0]    decel;
    logic [15:0]         halt_time;
    logic                unit_sel;
    logic [15:0]         switch_freq;
    logic [15:0]         max_freq;
    rts_cfg_s            cfg;
    logic [IRQ_W-1:0]    irq_stat;
    logic [IRQ_W-1:0]    irq_mask;
    logic                awready;
    logic                wready;
    logic                aw_have;
    logic                w_have;
    logic [7:0]          waddr;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic [1:0]          pair;
    logic                motor2;
    logic                conflict;
    logic                halting;
    logic                run_block;
    logic                run_ok;
    logic                halt_status;
    logic                coast;
    logic [15:0]         act_accel;
    logic [15:0]         act_decel;
    logic [31:0]         tick_cnt;
    logic                tick;
    logic [5:0]          div_cnt;
    logic [15:0]         divisor;
    logic [31:0]         dvd;
    logic [16:0]         rem;
    logic [31:0]         quo;
    logic [31:0]         step;
    logic                irq;
  } rts_st_s;
endpackage

/* core/rts_top.sv */
// ramp time selector: pair selection, fast stop latch, time units, ramp step and axi4-lite registers
// Notes on behaviour
// - each accel time is the ramp from 0 Hz to the maximum output frequency
// - each decel time is the ramp from maximum output frequency to 0 Hz
// - after reset pair 1 is active; accel defaults 60.0 s, decel 120.0 s
// - two select inputs form a code choosing one of four pairs; unassigned reads 0
// - with motor select, select1 picks pairs 1/2 for motor 1, 3/4 for motor 2
// - select2 and motor select both assigned raise a configuration conflict error
// - motor 2 selection is unavailable with a permanent-magnet motor
// - auto switching uses pair 4 below the switch frequency, else pair 1 or 3
// - a contact-selected pair overrides automatic frequency-level switching
// - a zero switch frequency disables automatic switching
// - fast stop latches on a momentary input and decelerates with the halt time
// - after fast stop, restart waits for stop, input release and a fresh run
// - the fast stop status output is high for the whole fast stop
// - faults and overheat pre-alarm may request the same latched fast stop
// - time unit 0 reads all times in 0.01 s steps
// - time unit 1, the default, reads all times in 0.1 s steps
// - changing to unit 0 is refused while any time is 600.1 s or more
// - coast stop bypasses the deceleration ramp
`timescale 1ns/1ps
`default_nettype none
module rts_top
  import rts_pkg::*;
#(
  parameter int TICK_FINE   = TICK_FINE_CYC,
  parameter int TICK_COARSE = TICK_COARSE_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire rts_in_s     pins,
  input  wire logic [15:0] out_freq,
  output logic [1:0]       active_pair,
  output logic [15:0]      active_accel_time,
  output logic [15:0]      active_decel_time,
  output logic [31:0]      ramp_step,
  output logic             ramp_tick,
  output logic             run_enable,
  output logic             halt_status_out,
  output logic             coast_stop,
  output logic             irq
);
  rts_st_s s;
  rts_st_s n;

  localparam rts_st_s RST_ST = '{
    accel: {4{ACCEL_RST}}, decel: {4{DECEL_RST}}, halt_time: HALT_TIME_RST,
    unit_sel: UNIT_SEL_RST, switch_freq: SWITCH_FREQ_RST, max_freq: MAX_FREQ_RST,
    awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] b);
    merge16 = {b[1] ? d[15:8] : old[15:8], b[0] ? d[7:0] : old[7:0]};
  endfunction

  logic             s1;
  logic             s2;
  logic             m_en;
  logic             contact;
  logic [1:0]       cpair;
  logic             trig;
  logic             wr_go;
  logic             too_long;
  logic [IRQ_W-1:0] ev;
  logic [16:0]      rem_sh;
  logic [31:0]      tick_len;
  logic [7:0]       ra;

  always_comb begin
    n = s;
    ev = '0;
    // pair selection from contacts, motor selection or frequency level
    n.conflict = s.cfg.sel2 & s.cfg.motor_sel;
    m_en = s.cfg.motor_sel & ~s.cfg.pm_motor & ~n.conflict;
    s1 = s.cfg.sel1 & pins.sel1;
    s2 = s.cfg.sel2 & pins.sel2;
    n.motor2 = m_en & pins.motor;
    contact = m_en ? s1 : (s1 | s2);
    cpair = m_en ? {n.motor2, s1} : {s2, s1};
    if (!contact && s.switch_freq != 16'h0000) begin
      n.pair = (out_freq < s.switch_freq) ? 2'h3 : {n.motor2, 1'b0};
    end else begin
      n.pair = cpair;
    end
    if (n.pair != s.pair) begin
      ev[IRQ_PAIR] = 1'b1;
    end
    if (n.conflict && !s.conflict) begin
      ev[IRQ_CONFLICT] = 1'b1;
    end

    // fast stop latch and restart lockout
    trig = (s.cfg.halt_no & pins.halt) | (s.cfg.halt_nc & ~pins.halt)
         | pins.fault_halt_req | (s.cfg.overheat_act & pins.overheat_prealarm);
    if (trig) begin
      n.halting = 1'b1;
      n.run_block = 1'b1;
      ev[IRQ_HALT] = ~s.halting;
    end else if (s.halting && pins.freq_zero) begin
      n.halting = 1'b0;
    end
    if (!n.halting && !pins.run_cmd) begin
      n.run_block = 1'b0;
    end
    n.run_ok = pins.run_cmd & ~n.run_block & ~n.halting;
    n.halt_status = n.halting & s.cfg.halt_stat_out;
    n.coast = s.cfg.coast_stop & ~pins.run_cmd & ~n.halting;

    // active times; the selected pair takes effect without touching the output frequency
    n.act_accel = s.accel[n.pair];
    n.act_decel = n.halting ? s.halt_time : s.decel[n.pair];

    // tick base follows the time unit
    tick_len = s.unit_sel ? 32'(TICK_COARSE) : 32'(TICK_FINE);
    n.tick = 1'b0;
    if (s.tick_cnt + 32'h1 >= tick_len) begin
      n.tick_cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.tick_cnt = s.tick_cnt + 32'h1;
    end

    // serial divider: step per tick is max frequency (16.16) over time in ticks
    rem_sh = {s.rem[15:0], s.dvd[31]};
    if (s.div_cnt == 6'h00) begin
      n.divisor = pins.ramp_up ? s.act_accel : s.act_decel;
      n.dvd = {s.max_freq, 16'h0000};
      n.rem = '0;
      n.quo = '0;
      n.div_cnt = DIV_STEPS;
    end else begin
      n.dvd = {s.dvd[30:0], 1'b0};
      if (rem_sh >= {1'b0, s.divisor}) begin
        n.rem = rem_sh - {1'b0, s.divisor};
        n.quo = {s.quo[30:0], 1'b1};
      end else begin
        n.rem = rem_sh;
        n.quo = {s.quo[30:0], 1'b0};
      end
      n.div_cnt = s.div_cnt - 6'h01;
      if (s.div_cnt == 6'h01) begin
        n.step = (s.divisor == 16'h0000) ? 32'hffffffff : n.quo;
      end
    end

    // write channel: address and data taken in either order
    if (s_axi_awvalid && s.awready) begin
      n.awready = 1'b0;
      n.aw_have = 1'b1;
      n.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      n.wready = 1'b0;
      n.w_have = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    too_long = 1'b0;
    for (int i = 0; i < 4; i++) begin
      too_long = too_long | (s.accel[i] >= UNIT_FINE_LIMIT) | (s.decel[i] >= UNIT_FINE_LIMIT);
    end
    too_long = too_long | (s.halt_time >= UNIT_FINE_LIMIT);
    wr_go = s.aw_have & s.w_have & ~s.bvalid;
    if (wr_go) begin
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (s.waddr)
        ADDR_ACCEL_A:     n.accel[0] = merge16(s.accel[0], s.wdata, s.wstrb);
        ADDR_DECEL_A:     n.decel[0] = merge16(s.decel[0], s.wdata, s.wstrb);
        ADDR_ACCEL_B:     n.accel[1] = merge16(s.accel[1], s.wdata, s.wstrb);
        ADDR_DECEL_B:     n.decel[1] = merge16(s.decel[1], s.wdata, s.wstrb);
        ADDR_ACCEL_C:     n.accel[2] = merge16(s.accel[2], s.wdata, s.wstrb);
        ADDR_DECEL_C:     n.decel[2] = merge16(s.decel[2], s.wdata, s.wstrb);
        ADDR_ACCEL_D:     n.accel[3] = merge16(s.accel[3], s.wdata, s.wstrb);
        ADDR_DECEL_D:     n.decel[3] = merge16(s.decel[3], s.wdata, s.wstrb);
        ADDR_HALT_TIME:   n.halt_time = merge16(s.halt_time, s.wdata, s.wstrb);
        ADDR_SWITCH_FREQ: n.switch_freq = merge16(s.switch_freq, s.wdata, s.wstrb);
        ADDR_MAX_FREQ:    n.max_freq = merge16(s.max_freq, s.wdata, s.wstrb);
        ADDR_UNIT_SEL: begin
          if (s.wstrb[0]) begin
            if (!s.wdata[0] && s.unit_sel && too_long) begin
              ev[IRQ_UNIT_REJ] = 1'b1;
              n.bresp = RESP_SLVERR;
            end else begin
              n.unit_sel = s.wdata[0];
            end
          end
        end
        ADDR_FUNC_CFG: begin
          if (s.wstrb[0]) begin
            n.cfg[7:0] = s.wdata[7:0];
          end
          if (s.wstrb[1]) begin
            n.cfg[8] = s.wdata[8];
          end
        end
        ADDR_IRQ_MASK: begin
          if (s.wstrb[0]) begin
            n.irq_mask = s.wdata[IRQ_W-1:0];
          end
        end
        ADDR_IRQ_STAT: begin
          if (s.wstrb[0]) begin
            n.irq_stat = s.irq_stat & ~s.wdata[IRQ_W-1:0];
          end
        end
        ADDR_STATUS: ;
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    // a new event wins over a clear in the same cycle
    n.irq_stat = n.irq_stat | ev;
    n.irq = |(n.irq_stat & n.irq_mask);
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.awready = 1'b1;
      n.wready = 1'b1;
    end

    // read channel
    ra = s_axi_araddr;
    if (s_axi_arvalid && s.arready) begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = '0;
      case (ra)
        ADDR_ACCEL_A:     n.rdata[15:0] = s.accel[0];
        ADDR_DECEL_A:     n.rdata[15:0] = s.decel[0];
        ADDR_ACCEL_B:     n.rdata[15:0] = s.accel[1];
        ADDR_DECEL_B:     n.rdata[15:0] = s.decel[1];
        ADDR_ACCEL_C:     n.rdata[15:0] = s.accel[2];
        ADDR_DECEL_C:     n.rdata[15:0] = s.decel[2];
        ADDR_ACCEL_D:     n.rdata[15:0] = s.accel[3];
        ADDR_DECEL_D:     n.rdata[15:0] = s.decel[3];
        ADDR_HALT_TIME:   n.rdata[15:0] = s.halt_time;
        ADDR_UNIT_SEL:    n.rdata[0] = s.unit_sel;
        ADDR_SWITCH_FREQ: n.rdata[15:0] = s.switch_freq;
        ADDR_MAX_FREQ:    n.rdata[15:0] = s.max_freq;
        ADDR_FUNC_CFG:    n.rdata[8:0] = s.cfg;
        ADDR_STATUS:      n.rdata[5:0] = {s.motor2, s.run_block, s.conflict, s.halting, s.pair};
        ADDR_IRQ_STAT:    n.rdata[IRQ_W-1:0] = s.irq_stat;
        ADDR_IRQ_MASK:    n.rdata[IRQ_W-1:0] = s.irq_mask;
        default:          n.rresp = RESP_SLVERR;
      endcase
    end else if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s <= RST_ST;
    end else begin
      s <= n;
    end
  end

  assign s_axi_awready     = s.awready;
  assign s_axi_wready      = s.wready;
  assign s_axi_bvalid      = s.bvalid;
  assign s_axi_bresp       = s.bresp;
  assign s_axi_arready     = s.arready;
  assign s_axi_rvalid      = s.rvalid;
  assign s_axi_rdata       = s.rdata;
  assign s_axi_rresp       = s.rresp;
  assign active_pair       = s.pair;
  assign active_accel_time = s.act_accel;
  assign active_decel_time = s.act_decel;
  assign ramp_step         = s.step;
  assign ramp_tick         = s.tick;
  assign run_enable        = s.run_ok;
  assign halt_status_out   = s.halt_status;
  assign coast_stop        = s.coast;
  assign irq               = s.irq;

  // helper: a refused switch to the fine unit
  logic unit_rej_try;
  assign unit_rej_try = wr_go && s.waddr == ADDR_UNIT_SEL && s.wstrb[0] && !s.wdata[0] && s.unit_sel && too_long;

  property p_halt_latch;
    @(posedge mclk) disable iff (!rst_n) (pins.fault_halt_req) |=> s.halting ##0 halt_status_out == s.cfg.halt_stat_out;
  endproperty
  a_halt_latch: assert property (p_halt_latch) else $error("fast stop did not latch");

  property p_halt_hold;
    @(posedge mclk) disable iff (!rst_n) (s.halting && !pins.freq_zero) |=> s.halting;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("fast stop ended before stop");

  property p_no_restart;
    @(posedge mclk) disable iff (!rst_n) $rose(s.halting) |-> !run_enable [*3];
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("run allowed during fast stop");

  property p_halt_time;
    @(posedge mclk) disable iff (!rst_n) s.halting |-> active_decel_time == $past(s.halt_time);
  endproperty
  a_halt_time: assert property (p_halt_time) else $error("fast stop time not used");

  property p_conflict;
    @(posedge mclk) disable iff (!rst_n) (s.cfg.sel2 && s.cfg.motor_sel) |=> s.conflict;
  endproperty
  a_conflict: assert property (p_conflict) else $error("conflict error missing");

  property p_pm_motor;
    @(posedge mclk) disable iff (!rst_n) s.cfg.pm_motor |=> !s.motor2;
  endproperty
  a_pm_motor: assert property (p_pm_motor) else $error("motor 2 selected with pm motor");

  property p_unit_rej;
    @(posedge mclk) disable iff (!rst_n) unit_rej_try |=> s.unit_sel && s.irq_stat[IRQ_UNIT_REJ] && s.bresp == RESP_SLVERR;
  endproperty
  a_unit_rej: assert property (p_unit_rej) else $error("unit change not refused");

  property p_auto_off;
    @(posedge mclk) disable iff (!rst_n)
      (s.switch_freq == 16'h0000 && !s.cfg.sel1 && !s.cfg.sel2 && !s.cfg.motor_sel) |=> active_pair == 2'h0;
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("auto switching while disabled");

  property p_auto_low;
    @(posedge mclk) disable iff (!rst_n)
      (s.switch_freq != 16'h0000 && out_freq < s.switch_freq && !(s.cfg.sel1 && pins.sel1)
       && !(s.cfg.sel2 && pins.sel2)) |=> active_pair == 2'h3;
  endproperty
  a_auto_low: assert property (p_auto_low) else $error("pair 4 not used below switch level");

  property p_contact_prio;
    @(posedge mclk) disable iff (!rst_n)
      (s.cfg.sel1 && pins.sel1 && !s.cfg.motor_sel && !s.cfg.sel2) |=> active_pair == 2'h1;
  endproperty
  a_contact_prio: assert property (p_contact_prio) else $error("contact selection overridden");

  property p_halt_stat;
    @(posedge mclk) disable iff (!rst_n) halt_status_out == (s.halting && $past(s.cfg.halt_stat_out));
  endproperty
  a_halt_stat: assert property (p_halt_stat) else $error("fast stop status output wrong");

  property p_run_lock;
    @(posedge mclk) disable iff (!rst_n) s.run_block |-> !run_enable;
  endproperty
  a_run_lock: assert property (p_run_lock) else $error("run allowed while restart is locked");

  property p_coast_halt;
    @(posedge mclk) disable iff (!rst_n) s.halting |-> !coast_stop;
  endproperty
  a_coast_halt: assert property (p_coast_halt) else $error("coast stop during fast stop");

  c_halt: cover property (@(posedge mclk) disable iff (!rst_n) $fell(s.halting) ##[1:20] run_enable);
  c_pair4: cover property (@(posedge mclk) disable iff (!rst_n) active_pair == 2'h3 ##1 active_pair == 2'h0);
  c_unit: cover property (@(posedge mclk) disable iff (!rst_n) unit_rej_try);
  c_fine: cover property (@(posedge mclk) disable iff (!rst_n) ramp_tick && !s.unit_sel);
endmodule // rts_top
`default_nettype wire

/* test/rts_contacts.sv */
// model of the contact inputs, run command and frequency feedback at the block's far side
`timescale 1ns/1ps
`default_nettype none
module rts_contacts
  import rts_pkg::*;
(
  input  wire logic        mclk,
  input  wire rts_in_s     req,
  input  wire logic [15:0] freq_req,
  output var  rts_in_s     pins,
  output var  logic [15:0] out_freq
);
  // contacts are sampled once per edge; run is re-issued only when the bench commands it
  always_ff @(posedge mclk) begin
    pins           <= req;
    pins.freq_zero <= (freq_req == 16'h0000);
    out_freq       <= freq_req;
  end
endmodule // rts_contacts
`default_nettype wire

/* test/tb_ramp_time_selector.sv */
// self-checking bench for the ramp time selector
`timescale 1ns/1ps
`default_nettype none
module tb_ramp_time_selector;
  import rts_pkg::*;
  logic        mclk, rst_n, awv, wv, bready, arv, rready, awr, wrdy, bv, arr, rv;
  logic        tick, run_en, hstat, coast, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rdv, step, seed;
  logic [1:0]  bresp, rresp, resp, pair;
  logic [15:0] acc, dec, freq_req, out_freq;
  logic [31:0] ta [4];
  logic [31:0] td [4];
  rts_in_s     req, pins;
  int          num_errors, tests_run, i;

  rts_top #(.TICK_FINE(10), .TICK_COARSE(100)) i_rts_top (
    .mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rready), .pins(pins), .out_freq(out_freq),
    .active_pair(pair), .active_accel_time(acc), .active_decel_time(dec), .ramp_step(step),
    .ramp_tick(tick), .run_enable(run_en), .halt_status_out(hstat), .coast_stop(coast), .irq(irq));

  rts_contacts i_rts_contacts (.mclk(mclk), .req(req), .freq_req(freq_req), .pins(pins), .out_freq(out_freq));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // step per tick in 16.16 form, saturated when the time is zero
  function automatic logic [31:0] exp_step(input logic [31:0] mx, input logic [31:0] t);
    if (t == 32'h0) return '1;
    return (mx << 16) / t;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata  <= d;
    awv    <= 1'b1;
    wv     <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (awr && awv) awv <= 1'b0;
      if (wrdy && wv) wv <= 1'b0;
      if (bv) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arv    <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (arr && arv) arv <= 1'b0;
      if (rv) begin
        rdv  = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic step_wait(input logic [31:0] e);
    int n;
    for (n = 0; n < 200 && step !== e; n++) @(posedge mclk);
    #1;
    chk("ramp step", step, e);
  endtask

  task automatic tgap(input logic [31:0] e);
    int n;
    int g;
    #1;
    for (n = 0; n < 400 && tick !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    g = 0;
    do begin
      @(posedge mclk);
      #1;
      g++;
    end while (tick !== 1'b1 && g < 400);
    chk("tick gap", g, e);
  endtask

  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge mclk);
    num_errors++;
    wrap_up;
  end

  initial begin
    {awv, wv, bready, arv, rready, awaddr, araddr, wdata} = '0;
    req = '0;
    freq_req = 16'h0190;
    rst_n = 1'b0;
    seed = 32'h13fcb;
    num_errors = 0;
    tests_run = 0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    req.ramp_up <= 1'b1;
    settle;
    chk("pair", pair, 32'h0);
    chk("accel", acc, ACCEL_RST);
    chk("decel", dec, DECEL_RST);
    for (i = 0; i < 8; i++) begin
      rd(8'(i * 4));
      chk("reset reg", rdv, i[0] ? DECEL_RST : ACCEL_RST);
    end
    rd(8'h40);
    chk("unmapped resp", resp, RESP_SLVERR);
    // random pair times, then every select code
    wr(ADDR_FUNC_CFG, 32'h3);
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      ta[i] = seed % 6001;
      seed = lfsr(seed);
      td[i] = seed % 6001;
      wr(8'(ADDR_ACCEL_A + 8 * i), ta[i]);
      wr(8'(ADDR_DECEL_A + 8 * i), td[i]);
    end
    for (i = 0; i < 4; i++) begin
      @(posedge mclk);
      req.sel1 <= i[0];
      req.sel2 <= i[1];
      settle;
      chk("pair", pair, i[1:0]);
      chk("accel", acc, ta[i]);
      chk("decel", dec, td[i]);
    end
    step_wait(exp_step(MAX_FREQ_RST, ta[3]));
    @(posedge mclk);
    req.ramp_up <= 1'b0;
    step_wait(exp_step(MAX_FREQ_RST, td[3]));
    // motor selection, magnet motor, conflict
    @(posedge mclk);
    req <= '{motor: 1'b1, run_cmd: 1'b1, default: 1'b0};
    wr(ADDR_FUNC_CFG, 32'h5);
    settle;
    chk("pair", pair, 32'h2);
    @(posedge mclk);
    req.sel1 <= 1'b1;
    settle;
    chk("pair", pair, 32'h3);
    wr(ADDR_FUNC_CFG, 32'h45);
    settle;
    chk("pair", pair, 32'h1);
    wr(ADDR_FUNC_CFG, 32'h7);
    rd(ADDR_STATUS);
    chk("conflict", rdv[3], 32'h1);
    // frequency-level switching against contact priority
    wr(ADDR_FUNC_CFG, 32'h1);
    @(posedge mclk);
    req.motor <= 1'b0;
    freq_req <= 16'h0032;
    wr(ADDR_SWITCH_FREQ, 32'h64);
    settle;
    chk("pair", pair, 32'h1);
    @(posedge mclk);
    req.sel1 <= 1'b0;
    settle;
    chk("pair", pair, 32'h3);
    @(posedge mclk);
    freq_req <= 16'h0096;
    settle;
    chk("pair", pair, 32'h0);
    @(posedge mclk);
    freq_req <= 16'h0032;
    wr(ADDR_SWITCH_FREQ, 32'h0);
    settle;
    chk("pair", pair, 32'h0);
    // coast stop method
    wr(ADDR_FUNC_CFG, 32'h80);
    @(posedge mclk);
    req.run_cmd <= 1'b0;
    settle;
    chk("coast", coast, 32'h1);
    @(posedge mclk);
    req.run_cmd <= 1'b1;
    settle;
    chk("coast", coast, 32'h0);
    chk("run", run_en, 32'h1);
    // momentary fast stop contact, status output and interrupt
    wr(ADDR_FUNC_CFG, 32'h28);
    wr(ADDR_HALT_TIME, 32'h123);
    @(posedge mclk);
    req.halt <= 1'b1;
    @(posedge mclk);
    req.halt <= 1'b0;
    settle;
    chk("halt status", hstat, 32'h1);
    chk("halt decel", dec, 32'h123);
    chk("run", run_en, 32'h0);
    chk("irq masked", irq, 32'h0);
    rd(ADDR_IRQ_STAT);
    chk("irq stat", rdv[IRQ_HALT], 32'h1);
    wr(ADDR_IRQ_MASK, 32'h1);
    settle;
    chk("irq", irq, 32'h1);
    @(posedge mclk);
    freq_req <= 16'h0000;
    settle;
    chk("halt status", hstat, 32'h0);
    chk("run", run_en, 32'h0);
    // the controlling side issues a fresh run command
    @(posedge mclk);
    req.run_cmd <= 1'b0;
    settle;
    @(posedge mclk);
    req.run_cmd <= 1'b1;
    settle;
    chk("run", run_en, 32'h1);
    wr(ADDR_IRQ_STAT, 32'h1);
    settle;
    chk("irq cleared", irq, 32'h0);
    // fault request takes the same latched path
    @(posedge mclk);
    freq_req <= 16'h0190;
    req.fault_halt_req <= 1'b1;
    @(posedge mclk);
    req.fault_halt_req <= 1'b0;
    freq_req <= 16'h0000;
    @(posedge mclk);
    #1;
    chk("fault halt", hstat, 32'h1);
    // overheat pre-alarm with the fast stop action selected
    wr(ADDR_FUNC_CFG, 32'h120);
    @(posedge mclk);
    freq_req <= 16'h0190;
    req.overheat_prealarm <= 1'b1;
    @(posedge mclk);
    req.overheat_prealarm <= 1'b0;
    freq_req <= 16'h0000;
    @(posedge mclk);
    #1;
    chk("overheat halt", hstat, 32'h1);
    // time units: refusal at the limit, then tick spacing
    wr(ADDR_ACCEL_A, 32'h1771);
    wr(ADDR_UNIT_SEL, 32'h0);
    chk("unit resp", resp, RESP_SLVERR);
    rd(ADDR_UNIT_SEL);
    chk("unit", rdv, 32'h1);
    wr(ADDR_ACCEL_A, 32'h1770);
    wr(ADDR_UNIT_SEL, 32'h0);
    chk("unit resp", resp, RESP_OKAY);
    tgap(32'ha);
    wr(ADDR_UNIT_SEL, 32'h1);
    tgap(32'h64);
    wrap_up;
  end
endmodule // tb_ramp_time_selector
`default_nettype wire
